// [rtl/spindle_speed_command_select.sv]
`timescale 1ns/1ps
`default_nettype none
module spindle_speed_command_select
  import spindle_cmd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Connector pins and analog sample
  input wire spindle_cmd_pkg::pins_t pins,
  input wire logic [11:0] speed_voltage_in,
  // Motor command and error display code
  output spindle_cmd_pkg::motor_t motor,
  output logic [7:0] display_code
);
  import spindle_cmd_pkg::*;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Whole bus word compared, so large writes clamp instead of wrapping
  function automatic logic [16:0] clamp_rng(input logic [31:0] v);
    if (v < 32'(speed_min_rpm)) return speed_min_rpm;
    if (v > 32'(speed_max_rpm)) return speed_max_rpm;
    return v[16:0];
  endfunction : clamp_rng

  function automatic logic [16:0] min2(input logic [16:0] a,
                                       input logic [16:0] b);
    return (a < b) ? a : b;
  endfunction : min2

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  pins_t pins_s;
  pin_sync #(.width($bits(pins_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  cfg_t cfg_q;
  logic [16:0] fixed_q;
  logic [16:0] max_q;
  logic [16:0] point_q [4];
  logic [16:0] panel_q;
  logic panel_run_q;
  logic panel_rev_q;
  logic [16:0] pulse_q;
  logic pulse_prev_q;
  logic [7:0] hist_q [history_depth];
  logic [2:0] hist_cnt_q;
  logic error_view_q;
  logic [16:0] speed_d;
  logic [16:0] ext_speed;
  logic [16:0] analog_speed;
  logic [16:0] sel_speed;

  logic wr_en;
  logic addr_ok;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    addr_ok = (paddr[1:0] == 2'b00) &&
              (paddr <= hist0_off + 8'h10);
  end

  // Configuration, one write per access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      fixed_q <= fixed_rst;
      max_q <= max_rst;
      panel_q <= point_rst;
      for (int i = 0; i < 4; i++) point_q[i] <= point_rst;
    end else if (wr_en) begin
      unique case (paddr)
        cfg_off: cfg_q <= cfg_t'(pwdata[cfg_w-1:0]);
        fixed_off: fixed_q <= clamp_rng(pwdata);
        max_off: max_q <= clamp_rng(pwdata);
        panel_off: panel_q <= clamp_rng(pwdata);
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (paddr == point0_off + 8'(4 * i))
              point_q[i] <= clamp_rng(pwdata);
          end
        end
      endcase
    end
  end

  // Panel start/stop and history view command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_run_q <= 1'b0;
      panel_rev_q <= 1'b0;
      error_view_q <= 1'b0;
    end else if (wr_en && paddr == cmd_off) begin
      panel_run_q <= pwdata[0];
      panel_rev_q <= pwdata[1];
      error_view_q <= pwdata[2];
    end
  end

  // ----------------------------------------------------------
  // Pulse setpoint
  // ----------------------------------------------------------
  // Edge taken from synchronised pin, so glitches shorter than 1 clock can be lost
  logic pulse_edge;
  assign pulse_edge = pins_s.speed_count_pulse_in && !pulse_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_prev_q <= 1'b0;
      pulse_q <= pulse_rst;
    end else begin
      pulse_prev_q <= pins_s.speed_count_pulse_in;
      if (pulse_edge && cfg_q.external_speed_mode_param == src_pulse) begin
        if (pins_s.speed_updown_in) begin
          pulse_q <= (pulse_q > speed_max_rpm - pulse_step_rpm) ?
                     speed_max_rpm : pulse_q + pulse_step_rpm;
        end else begin
          pulse_q <= (pulse_q < speed_min_rpm + pulse_step_rpm) ?
                     speed_min_rpm : pulse_q - pulse_step_rpm;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Speed selection and limits
  // ----------------------------------------------------------
  always_comb begin
    logic [29:0] prod;
    prod = '0;
    prod = 30'(speed_voltage_in) *
      30'(cfg_q.analog_scale_param ? analog_fs_hi_rpm
                                   : analog_fs_lo_rpm);
    analog_speed = 17'(prod / 30'd4095);
  end

  assign sel_speed = point_q[{pins_s.speed_point_sel_hi,
                              pins_s.speed_point_sel_lo}];

  always_comb begin
    unique case (cfg_q.external_speed_mode_param)
      src_analog: ext_speed = analog_speed;
      src_pulse: ext_speed = pulse_q;
      src_point: ext_speed = sel_speed;
      src_resvd: ext_speed = analog_speed;
    endcase
  end

  always_comb begin
    speed_d = cfg_q.auto_speed_source_param ? panel_q : ext_speed;
    if (cfg_q.fixed_speed_param) speed_d = fixed_q;
    if (cfg_q.max_speed_param || cfg_q.fixed_speed_param)
      speed_d = min2(speed_d, max_q);
    if (cfg_q.air_override_param)
      speed_d = min2(speed_d, air_cap_rpm);
    speed_d = min2(speed_d, motor_cap_rpm);
  end

  // ----------------------------------------------------------
  // Start, direction and emergency stop
  // ----------------------------------------------------------
  logic estop_trip;
  assign estop_trip = cfg_q.estop_enable_param &&
    !pins_s.estop_chan_a && !pins_s.estop_chan_b;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor <= '0;
    end else begin
      motor.speed_cmd <= speed_d;
      motor.relay_closed <= !estop_trip;
      if (estop_trip) begin
        motor.run <= 1'b0;
        motor.reverse <= 1'b0;
      end else if (cfg_q.signal_start_mode_param) begin
        motor.run <= pins_s.start_in;
        motor.reverse <= pins_s.dir_in;
      end else begin
        motor.run <= panel_run_q;
        motor.reverse <= panel_rev_q;
      end
    end
  end

  // ----------------------------------------------------------
  // Error history
  // ----------------------------------------------------------
  // No clear path: only reset empties it; the outside store reloads it
  logic hist_push;
  assign hist_push = wr_en && paddr == err_push_off &&
                     pwdata[7:0] != hist_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < history_depth; i++) hist_q[i] <= hist_empty;
      hist_cnt_q <= 3'd0;
    end else if (hist_push) begin
      hist_q[0] <= pwdata[7:0];
      for (int i = 1; i < history_depth; i++) hist_q[i] <= hist_q[i-1];
      if (hist_cnt_q < 3'(history_depth)) hist_cnt_q <= hist_cnt_q + 3'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_code <= hist_empty;
    end else begin
      display_code <= (error_view_q && hist_cnt_q == 3'd0) ?
                      8'h2d : hist_q[0];
    end
  end

  // ----------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------
  // Every access answers at its first access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        if (paddr == cfg_off) prdata <= 32'(cfg_q);
        else if (paddr == fixed_off) prdata <= 32'(fixed_q);
        else if (paddr == max_off) prdata <= 32'(max_q);
        else if (paddr == panel_off) prdata <= 32'(panel_q);
        else if (paddr == status_off) prdata <= 32'({hist_cnt_q,
          estop_trip, motor.run, motor.reverse, speed_d});
        else if (paddr == cmd_off) prdata <= 32'({error_view_q,
          panel_rev_q, panel_run_q});
        else begin
          for (int i = 0; i < 4; i++)
            if (paddr == point0_off + 8'(4 * i)) prdata <= 32'(point_q[i]);
          for (int i = 0; i < history_depth; i++)
            if (paddr == hist0_off + 8'(4 * i)) prdata <= 32'(hist_q[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_estop_relay: assert property (
    @(posedge pclk) disable iff (!presetn)
    estop_trip |=> !motor.relay_closed && !motor.run)
    else $error("estop did not open relay");
  a_air_cap: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.air_override_param |=> motor.speed_cmd <= air_cap_rpm)
    else $error("air cap exceeded");
  a_max_limit: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.max_speed_param
      |=> motor.speed_cmd <= $past(max_q))
    else $error("max limit exceeded");
  a_fixed_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.fixed_speed_param && !cfg_q.air_override_param && fixed_q <= max_q
      |=> motor.speed_cmd == $past(fixed_q))
    else $error("fixed speed not held");
  a_pulse_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_edge && cfg_q.external_speed_mode_param == src_pulse &&
    pins_s.speed_updown_in && pulse_q <= speed_max_rpm - pulse_step_rpm
      |=> pulse_q == $past(pulse_q) + pulse_step_rpm)
    else $error("pulse step wrong");
  a_pulse_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_q >= speed_min_rpm && pulse_q <= speed_max_rpm)
    else $error("pulse setpoint out of range");
  a_hist_shift: assert property (
    @(posedge pclk) disable iff (!presetn)
    hist_push |=> hist_q[0] == $past(pwdata[7:0]) &&
      hist_q[1] == $past(hist_q[0]))
    else $error("history not shifted");
  a_start_pins: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.signal_start_mode_param && !estop_trip
      |=> motor.run == $past(pins_s.start_in))
    else $error("start pin not followed");
  a_point_sel: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.external_speed_mode_param == src_point && !cfg_q.fixed_speed_param
      && !cfg_q.max_speed_param && !cfg_q.air_override_param
      && !cfg_q.auto_speed_source_param
      |-> speed_d == sel_speed)
    else $error("speed point select wrong");
  a_pulse_down: assert property (
    @(posedge pclk) disable iff (!presetn)
    pulse_edge && cfg_q.external_speed_mode_param == src_pulse &&
    !pins_s.speed_updown_in && pulse_q >= speed_min_rpm + pulse_step_rpm
      |=> pulse_q == $past(pulse_q) - pulse_step_rpm)
    else $error("pulse down step wrong");
  a_reverse_pin: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_q.signal_start_mode_param && !estop_trip
      |=> motor.reverse == $past(pins_s.dir_in))
    else $error("direction pin not followed");
  a_relay_restore: assert property (
    @(posedge pclk) disable iff (!presetn)
    !estop_trip |=> motor.relay_closed)
    else $error("relay open without stop");
  a_hist_dash: assert property (
    @(posedge pclk) disable iff (!presetn)
    error_view_q && hist_cnt_q == 3'd0 |=> display_code == 8'h2d)
    else $error("empty history not dashed");
  a_hist_count: assert property (
    @(posedge pclk) disable iff (!presetn)
    hist_cnt_q <= 3'(history_depth))
    else $error("history count over depth");
endmodule : spindle_speed_command_select
`default_nettype wire

// [pkg/spindle_cmd_pkg.sv]
`default_nettype none
package spindle_cmd_pkg;
  // Speeds are in rpm
  localparam logic [16:0] pulse_step_rpm = 17'd1000;
  localparam logic [16:0] speed_min_rpm = 17'd1000;
  localparam logic [16:0] speed_max_rpm = 17'd80000;
  localparam logic [16:0] air_cap_rpm = 17'd30000;
  localparam logic [16:0] analog_fs_lo_rpm = 17'd60000;
  localparam logic [16:0] analog_fs_hi_rpm = 17'd80000;
  localparam logic [16:0] motor_cap_rpm = 17'd80000;
  localparam int history_depth = 5;

  // APB register byte offsets
  localparam logic [7:0] cfg_off = 8'h00;
  localparam logic [7:0] fixed_off = 8'h04;
  localparam logic [7:0] max_off = 8'h08;
  localparam logic [7:0] point0_off = 8'h0c;
  localparam logic [7:0] panel_off = 8'h1c;
  localparam logic [7:0] status_off = 8'h20;
  localparam logic [7:0] cmd_off = 8'h24;
  localparam logic [7:0] err_push_off = 8'h28;
  localparam logic [7:0] hist0_off = 8'h2c;

  // Reset values
  localparam logic [16:0] fixed_rst = 17'd1000;
  localparam logic [16:0] max_rst = 17'd80000;
  localparam logic [16:0] point_rst = 17'd1000;
  localparam logic [16:0] pulse_rst = 17'd1000;
  localparam logic [7:0] hist_empty = 8'h00;

  typedef enum logic [1:0] {
    src_analog, src_pulse, src_point, src_resvd
  } ext_mode_t;

  typedef struct packed {
    logic auto_speed_source_param;
    logic fixed_speed_param;
    logic max_speed_param;
    ext_mode_t external_speed_mode_param;
    logic signal_start_mode_param;
    logic air_override_param;
    logic analog_scale_param;
    logic estop_enable_param;
  } cfg_t;

  localparam int cfg_w = 9;

  typedef struct packed {
    logic speed_count_pulse_in;
    logic speed_updown_in;
    logic speed_point_sel_lo;
    logic speed_point_sel_hi;
    logic start_in;
    logic dir_in;
    logic estop_chan_a;
    logic estop_chan_b;
  } pins_t;

  typedef struct packed {
    logic run;
    logic reverse;
    logic relay_closed;
    logic [16:0] speed_cmd;
  } motor_t;
endpackage : spindle_cmd_pkg
`default_nettype wire

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta_q;
  // Stage one feeds stage two only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [verification/machine_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module machine_ctrl_model
  import spindle_cmd_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire logic [1:0] sel,
  input wire logic start,
  input wire logic dir,
  input wire logic estop_open,
  // Connector contacts
  output spindle_cmd_pkg::pins_t pins
);
  logic pulse_q = 1'b0;
  logic updown_q = 1'b0;
  // ----------------------------------------
  // Contact map, 1 = closed
  // ----------------------------------------
  // Both channels closed unless a stop is asked
  assign pins = {pulse_q, updown_q, sel[0], sel[1], start, dir,
                 ~estop_open, ~estop_open};
  // ----------------------------------------
  // Count pulse
  // ----------------------------------------
  // Direction settles well before the edge, so no race at sampling
  task automatic pulse(input logic up);
    @(posedge pclk);
    updown_q <= up;
    repeat (2) @(posedge pclk);
    pulse_q <= 1'b1;
    repeat (3) @(posedge pclk);
    pulse_q <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
endmodule : machine_ctrl_model
`default_nettype wire

// [verification/tb_spindle_speed_command_select.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_spindle_speed_command_select;
  import spindle_cmd_pkg::*;
  typedef struct packed {
    logic [8:0] cfg;
    logic [16:0] fix;
    logic [1:0] sel;
    logic [16:0] exp;
  } row_t;
  // ----------------------------------------
  // Speed source and limit cases
  // ----------------------------------------
  localparam row_t rows [14] = '{
    '{9'h000, 17'd20000, 2'd0, 17'd60000},
    '{9'h002, 17'd20000, 2'd0, 17'd80000},
    '{9'h006, 17'd20000, 2'd0, 17'd30000},
    '{9'h042, 17'd20000, 2'd0, 17'd50000},
    '{9'h046, 17'd20000, 2'd0, 17'd30000},
    '{9'h020, 17'd20000, 2'd0, 17'd11000},
    '{9'h020, 17'd20000, 2'd1, 17'd22000},
    '{9'h020, 17'd20000, 2'd2, 17'd33000},
    '{9'h020, 17'd20000, 2'd3, 17'd44000},
    '{9'h100, 17'd20000, 2'd0, 17'd5000},
    '{9'h080, 17'd20000, 2'd0, 17'd20000},
    '{9'h0a0, 17'd20000, 2'd3, 17'd20000},
    '{9'h080, 17'd70000, 2'd0, 17'd50000},
    '{9'h030, 17'd20000, 2'd0, 17'd60000}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pins_t pins;
  logic [11:0] volt = 12'hfff;
  motor_t motor;
  logic [7:0] disp;
  logic [1:0] m_sel = 2'd0;
  logic m_start = 1'b0;
  logic m_dir = 1'b0;
  logic m_open = 1'b0;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int cmp_count = 0;
  always #12.5 pclk = ~pclk;
  spindle_speed_command_select dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .speed_voltage_in(volt), .motor(motor),
    .display_code(disp));
  machine_ctrl_model partner (.pclk(pclk), .sel(m_sel), .start(m_start),
    .dir(m_dir), .estop_open(m_open), .pins(pins));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until pready is seen; no latency assumed
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        $display("BAD %0t no pready", $time);
        final_report();
      end
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, point0_off, 32'd90000);
    apb(1'b0, point0_off, 32'h0);
    chk(rd, 32'd80000);
    apb(1'b1, point0_off, 32'h0);
    apb(1'b0, point0_off, 32'h0);
    chk(rd, 32'd1000);
    apb(1'b1, point0_off, 32'h00030000);
    apb(1'b0, point0_off, 32'h0);
    chk(rd, 32'd80000);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, point0_off + 8'(4 * i), 32'(11000 * (i + 1)));
    end
    apb(1'b1, max_off, 32'd50000);
    apb(1'b1, panel_off, 32'd5000);
    foreach (rows[i]) begin
      apb(1'b1, fixed_off, 32'(rows[i].fix));
      apb(1'b1, cfg_off, 32'(rows[i].cfg));
      m_sel <= rows[i].sel;
      settle();
      chk(32'(motor.speed_cmd), 32'(rows[i].exp));
    end
    // Mid-scale voltage under both scale settings
    volt <= 12'h800;
    apb(1'b1, cfg_off, 32'h000);
    settle();
    chk(32'(motor.speed_cmd), 32'(2048 * 60000 / 4095));
    apb(1'b1, cfg_off, 32'h002);
    settle();
    chk(32'(motor.speed_cmd), 32'(2048 * 80000 / 4095));
    volt <= 12'hfff;
    // Pulse counting, including both saturation ends
    apb(1'b1, cfg_off, 32'h010);
    repeat (3) partner.pulse(1'b1);
    settle();
    chk(32'(motor.speed_cmd), 32'd4000);
    repeat (5) partner.pulse(1'b0);
    settle();
    chk(32'(motor.speed_cmd), 32'd1000);
    repeat (85) partner.pulse(1'b1);
    settle();
    chk(32'(motor.speed_cmd), 32'd80000);
    // Start and direction from the connector, then from the panel command
    m_start <= 1'b1;
    m_dir <= 1'b1;
    apb(1'b1, cfg_off, 32'h008);
    settle();
    chk({30'h0, motor.run, motor.reverse}, 32'h3);
    m_dir <= 1'b0;
    settle();
    chk({30'h0, motor.run, motor.reverse}, 32'h2);
    apb(1'b1, cfg_off, 32'h000);
    settle();
    chk(32'(motor.run), 32'h0);
    apb(1'b1, cmd_off, 32'h3);
    settle();
    chk({30'h0, motor.run, motor.reverse}, 32'h3);
    apb(1'b1, cmd_off, 32'h0);
    m_start <= 1'b0;
    // Stop channels open: relay only opens when the function is on
    m_open <= 1'b1;
    settle();
    chk(32'(motor.relay_closed), 32'h1);
    apb(1'b1, cfg_off, 32'h001);
    settle();
    chk(32'(motor.relay_closed), 32'h0);
    m_open <= 1'b0;
    apb(1'b1, cfg_off, 32'h000);
    // History: empty view, overflow, read-only slots
    apb(1'b1, cmd_off, 32'h4);
    settle();
    chk(32'(disp), 32'h2d);
    for (int i = 1; i <= 6; i++) begin
      apb(1'b1, err_push_off, 32'(i));
    end
    apb(1'b1, err_push_off, 32'h0);
    apb(1'b1, hist0_off, 32'h0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, hist0_off + 8'(4 * i), 32'h0);
      chk(rd, 32'(6 - i));
    end
    settle();
    chk(32'(disp), 32'h06);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    // Mid-run reset; the outside store must reload settings after it
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(motor), 32'h0);
    chk(32'(disp), 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(motor.relay_closed), 32'h1);
    chk(32'(motor.speed_cmd), 32'd60000);
    apb(1'b0, hist0_off, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, err_push_off, 32'h42);
    apb(1'b0, hist0_off, 32'h0);
    chk(rd, 32'h42);
    apb(1'b1, cfg_off, 32'h1ff);
    apb(1'b0, cfg_off, 32'h0);
    chk(rd, 32'h1ff);
    final_report();
  end
endmodule : tb_spindle_speed_command_select
`default_nettype wire
